// file: failure_watchdog.sv
// Windowed failure watchdog with AXI4-Lite register access
// Behaviour
// - 12-bit down counter behind 7-bit prescaler, divide by 2 to the power of a 3-bit setting
// - Failure gives interrupt or reset, as selected
// - Underflow without reload raises failure response
// - Reload restores counter from reload register
// - Reload at count >= delta is failure
// - Counter may freeze during debug halt
// - Lock makes configuration writes ignored
// - Count clock from internal or crystal oscillator
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_defs.svh"

module failure_watchdog
  import watchdog_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Register bus
  input wire axil_req_s axi_req_in,
  output axil_rsp_s axi_rsp_out,
  // Low-speed clock pins and debug state
  input wire logic low_speed_internal_oscillator_in,
  input wire logic low_speed_crystal_oscillator_in,
  input wire logic debug_halt_in,
  // Failure responses
  output logic irq_out,
  output logic sys_reset_out
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    axil_rsp_s rsp;
    wr_state_e wr_state;
    logic aw_got;
    logic w_got;
    logic [`ADDR_W-1:0] awaddr_q;
    logic [`DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    ctrl_s ctrl;
    logic [`CNT_W-1:0] reload;
    logic [`CNT_W-1:0] delta;
    logic [`CNT_W-1:0] count;
    logic locked;
    logic [`EVT_W-1:0] status;
    logic [`EVT_W-1:0] mask;
    logic irq;
    logic sys_rst;
    logic [`HOLD_W-1:0] hold;
  } top_s;

  top_s s_r;
  top_s s_nxt;

  logic tick;
  logic halt;
  logic dec;

  // --------------------------------------------------------------------------
  // Count clock path
  // --------------------------------------------------------------------------
  lowspeed_tick_sync u_sync (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .low_speed_internal_oscillator_in(low_speed_internal_oscillator_in),
    .low_speed_crystal_oscillator_in(low_speed_crystal_oscillator_in),
    .debug_halt_in(debug_halt_in),
    .clk_ext_in(s_r.ctrl.clk_ext),
    .tick_out(tick),
    .halt_out(halt)
  );

  tick_prescaler u_psc (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .clear_in(!s_r.ctrl.enable),
    .tick_in(tick),
    .div_in(s_r.ctrl.div),
    .dec_out(dec)
  );

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [`DATA_W-1:0] merge(input logic [`DATA_W-1:0] old_v,
                                               input logic [`DATA_W-1:0] new_v,
                                               input logic [3:0] strb);
    logic [`DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic [`DATA_W-1:0] pad12(input logic [`CNT_W-1:0] v);
    return {{(`DATA_W-`CNT_W){1'b0}}, v};
  endfunction

  function automatic logic [`DATA_W-1:0] pad2(input logic [`EVT_W-1:0] v);
    return {{(`DATA_W-`EVT_W){1'b0}}, v};
  endfunction

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  logic [`DATA_W-1:0] cur;
  logic [`DATA_W-1:0] wd;
  logic do_write;
  logic kick;
  logic ev_uf;
  logic ev_early;
  logic [`EVT_W-1:0] clr;
  logic [`DATA_W-1:0] rd;
  logic rd_err;

  always_comb
  begin
    s_nxt = s_r;
    cur = '0;
    wd = '0;
    kick = 1'b0;
    ev_uf = 1'b0;
    ev_early = 1'b0;
    clr = '0;
    rd = '0;
    rd_err = 1'b0;
    do_write = (s_r.wr_state == BUS_IDLE) && s_r.aw_got && s_r.w_got;

    // Address and data may arrive in either order
    if (s_r.rsp.awready && axi_req_in.awvalid)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr_q = axi_req_in.awaddr;
    end
    if (s_r.rsp.wready && axi_req_in.wvalid)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata_q = axi_req_in.wdata;
      s_nxt.wstrb_q = axi_req_in.wstrb;
    end

    // Current contents of the addressed register, for byte-lane merge
    if (s_r.awaddr_q == `OFF_CTRL)
      cur = {{(`DATA_W-`CTRL_W){1'b0}}, s_r.ctrl};
    else if (s_r.awaddr_q == `OFF_RELOAD)
      cur = pad12(s_r.reload);
    else if (s_r.awaddr_q == `OFF_DELTA)
      cur = pad12(s_r.delta);
    else if (s_r.awaddr_q == `OFF_MASK)
      cur = pad2(s_r.mask);
    wd = merge(cur, s_r.wdata_q, s_r.wstrb_q);

    // --------------------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------------------
    if (do_write)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.wr_state = BUS_RESP;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = `RESP_OKAY;
      // Locked configuration writes still answer OKAY, but change nothing
      if (s_r.awaddr_q == `OFF_CTRL)
      begin
        if (!s_r.locked)
          s_nxt.ctrl = wd[`CTRL_W-1:0];
      end
      else if (s_r.awaddr_q == `OFF_RELOAD)
      begin
        if (!s_r.locked)
          s_nxt.reload = wd[`CNT_W-1:0];
      end
      else if (s_r.awaddr_q == `OFF_DELTA)
      begin
        if (!s_r.locked)
          s_nxt.delta = wd[`CNT_W-1:0];
      end
      else if (s_r.awaddr_q == `OFF_KICK)
        kick = (wd == `KICK_KEY) && s_r.ctrl.enable;
      else if (s_r.awaddr_q == `OFF_LOCK)
        s_nxt.locked = (wd != `UNLOCK_KEY);
      else if (s_r.awaddr_q == `OFF_STATUS)
        clr = wd[`EVT_W-1:0];
      else if (s_r.awaddr_q == `OFF_MASK)
        s_nxt.mask = wd[`EVT_W-1:0];
      else if (s_r.awaddr_q == `OFF_COUNT)
        s_nxt.rsp.bresp = `RESP_OKAY;
      else
        s_nxt.rsp.bresp = `RESP_SLVERR;
    end

    if ((s_r.wr_state == BUS_RESP) && s_r.rsp.bvalid && axi_req_in.bready)
    begin
      s_nxt.rsp.bvalid = 1'b0;
      s_nxt.wr_state = BUS_IDLE;
    end
    s_nxt.rsp.awready = !s_nxt.aw_got;
    s_nxt.rsp.wready = !s_nxt.w_got;

    // --------------------------------------------------------------------------
    // Register reads
    // --------------------------------------------------------------------------
    if (axi_req_in.araddr == `OFF_CTRL)
      rd = {{(`DATA_W-`CTRL_W){1'b0}}, s_r.ctrl};
    else if (axi_req_in.araddr == `OFF_RELOAD)
      rd = pad12(s_r.reload);
    else if (axi_req_in.araddr == `OFF_DELTA)
      rd = pad12(s_r.delta);
    else if (axi_req_in.araddr == `OFF_KICK)
      rd = '0;
    else if (axi_req_in.araddr == `OFF_LOCK)
      rd = {{(`DATA_W-1){1'b0}}, s_r.locked};
    else if (axi_req_in.araddr == `OFF_STATUS)
      rd = pad2(s_r.status);
    else if (axi_req_in.araddr == `OFF_MASK)
      rd = pad2(s_r.mask);
    else if (axi_req_in.araddr == `OFF_COUNT)
      rd = pad12(s_r.count);
    else
      rd_err = 1'b1;

    if (s_r.rsp.arready && axi_req_in.arvalid)
    begin
      s_nxt.rsp.arready = 1'b0;
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rdata = rd;
      s_nxt.rsp.rresp = rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_r.rsp.rvalid && axi_req_in.rready)
    begin
      s_nxt.rsp.rvalid = 1'b0;
      s_nxt.rsp.arready = 1'b1;
    end

    // --------------------------------------------------------------------------
    // Counter
    // --------------------------------------------------------------------------
    if (!s_r.ctrl.enable)
      s_nxt.count = s_nxt.reload;
    else if (kick)
    begin
      // Reload before the window opens is itself a failure
      if (s_r.count >= s_r.delta)
        ev_early = 1'b1;
      s_nxt.count = s_r.reload;
    end
    else if (dec && !(s_r.ctrl.freeze && halt))
    begin
      if (s_r.count == '0)
      begin
        ev_uf = 1'b1;
        s_nxt.count = s_r.reload;
      end
      else
        s_nxt.count = s_r.count - `CNT_W'(1);
    end

    // --------------------------------------------------------------------------
    // Events and failure response
    // --------------------------------------------------------------------------
    // A new event wins over a clear in the same cycle
    s_nxt.status = (s_r.status & ~clr) | {ev_early, ev_uf};
    s_nxt.irq = !s_nxt.ctrl.rst_mode && |(s_nxt.status & s_nxt.mask);
    if ((ev_uf || ev_early) && s_r.ctrl.rst_mode)
    begin
      s_nxt.sys_rst = 1'b1;
      s_nxt.hold = `RST_HOLD_CYC;
    end
    else if (s_r.sys_rst)
    begin
      if (s_r.hold == '0)
        s_nxt.sys_rst = 1'b0;
      else
        s_nxt.hold = s_r.hold - `HOLD_W'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_r <= '0;
      s_r.rsp.awready <= 1'b1;
      s_r.rsp.wready <= 1'b1;
      s_r.rsp.arready <= 1'b1;
      s_r.ctrl <= `CTRL_RST;
      s_r.reload <= `RELOAD_RST;
      s_r.delta <= `DELTA_RST;
      s_r.count <= `RELOAD_RST;
      s_r.mask <= `MASK_RST;
    end
    else
      s_r <= s_nxt;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign axi_rsp_out = s_r.rsp;
  assign irq_out = s_r.irq;
  assign sys_reset_out = s_r.sys_rst;

endmodule
`default_nettype wire

// file: failure_watchdog_bench.sv
// Self-checking bench for the failure watchdog
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_defs.svh"

module failure_watchdog_bench
  import watchdog_pkg::*;
;
  logic clk, nrst, osc_i, osc_x, halt, irq, srst;
  axil_req_s rq;
  axil_rsp_s rs;
  logic [31:0] m [8];
  int n_errors = 0;
  int n_checks = 0;

  failure_watchdog i_failure_watchdog (
    .core_clk_in(clk),
    .nrst_in(nrst),
    .axi_req_in(rq),
    .axi_rsp_out(rs),
    .low_speed_internal_oscillator_in(osc_i),
    .low_speed_crystal_oscillator_in(osc_x),
    .debug_halt_in(halt),
    .irq_out(irq),
    .sys_reset_out(srst)
  );

  // Oscillators toggle on core clock falling edges, off the rising edges
  always #2.5 clk = ~clk;
  always #40 osc_i = ~osc_i;
  always #60 osc_x = ~osc_x;

  // ----------------------------------------
  // Bus tasks and model
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] sm;
    logic [31:0] dm;
    sm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    dm = d & sm;
    @(posedge clk);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.wstrb <= s;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
    end while (!rs.bvalid);
    rq.bready <= 1'b0;
    chk("wr resp", (a < 8'h20) ? `RESP_OKAY : `RESP_SLVERR, rs.bresp);
    if (a < `OFF_KICK && m[4] == 0) m[a[4:2]] = (dm | (m[a[4:2]] & ~sm)) & ((a == 0) ? 32'h7f : 32'hfff);
    if (a == `OFF_LOCK) m[4] = (dm != `UNLOCK_KEY);
    if (a == `OFF_STATUS) m[5] = m[5] & ~dm;
    if (a == `OFF_MASK) m[6] = (dm | (m[6] & ~sm)) & 32'h3;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rs.arready) rq.arvalid <= 1'b0;
    end while (!rs.rvalid);
    d = rs.rdata;
    r = rs.rresp;
    rq.rready <= 1'b0;
  endtask

  task automatic rv(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rd resp", `RESP_OKAY, r);
    chk("rd data", m[a[4:2]], d);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    logic [31:0] d, c0, c1;
    logic [1:0] r;
    int p, k, e;
    clk = 0;
    nrst = 0;
    rq = '0;
    osc_i = 0;
    osc_x = 0;
    halt = 0;
    m = '{0, 'hfff, 'hfff, 0, 0, 0, 0, 'hfff};
    void'($urandom(71));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (k = 0; k < 8; k++) if (k != 3) rv(8'(k * 4));
    rd(8'h20, d, r);
    chk("bad rd resp", `RESP_SLVERR, r);
    chk("bad rd data", 0, d);
    w(8'h24, 1);
    w(`OFF_LOCK, 0);
    w(`OFF_RELOAD, 'h123);
    w(`OFF_CTRL, 1);
    w(`OFF_DELTA, 5);
    rv(`OFF_RELOAD);
    rv(`OFF_CTRL);
    rv(`OFF_DELTA);
    rv(`OFF_LOCK);
    w(`OFF_LOCK, `UNLOCK_KEY);
    w(`OFF_RELOAD, 'h123);
    rv(`OFF_RELOAD);
    // Decrement rate per clock source and prescale
    for (k = 0; k < 2; k++)
    begin
      p = $urandom % 3;
      w(`OFF_CTRL, (p << 4) | (k << 3) | 1);
      e = (k ? 24 : 16) << p;
      rd(`OFF_COUNT, c0, r);
      repeat (40 * e) @(posedge clk);
      rd(`OFF_COUNT, c1, r);
      e = int'(c0 - c1) - 40;
      chk("rate", 1, e >= -1 && e <= 1);
      w(`OFF_CTRL, 0);
    end
    // Byte lanes: only the low byte of the reload value changes
    w(`OFF_RELOAD, 'habc, 4'h1);
    rv(`OFF_RELOAD);
    w(`OFF_MASK, 3);
    w(`OFF_RELOAD, 'h40);
    w(`OFF_DELTA, 'h20);
    w(`OFF_CTRL, 1);
    w(`OFF_KICK, `KICK_KEY);
    m[5] = 2;
    repeat (2) @(posedge clk);
    rv(`OFF_STATUS);
    chk("irq early", 1, irq);
    w(`OFF_STATUS, 2);
    do rd(`OFF_COUNT, d, r); while (d >= 'h20);
    w(`OFF_KICK, `KICK_KEY);
    rd(`OFF_COUNT, d, r);
    chk("reload", 1, d >= 'h3e);
    rv(`OFF_STATUS);
    w(`OFF_MASK, 2);
    do rd(`OFF_STATUS, d, r); while (!d[0]);
    chk("irq masked", 0, irq);
    w(`OFF_MASK, 3);
    @(posedge clk);
    chk("irq unmasked", 1, irq);
    w(`OFF_CTRL, 0);
    w(`OFF_STATUS, 1);
    @(posedge clk);
    chk("irq cleared", 0, irq);
    rv(`OFF_STATUS);
    w(`OFF_CTRL, 5);
    halt <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`OFF_COUNT, c0, r);
    repeat (100) @(posedge clk);
    rd(`OFF_COUNT, c1, r);
    chk("frozen", c0, c1);
    halt <= 1'b0;
    repeat (100) @(posedge clk);
    rd(`OFF_COUNT, c1, r);
    chk("resumed", 1, c1 < c0);
    w(`OFF_CTRL, 0);
    w(`OFF_RELOAD, 'h10);
    w(`OFF_CTRL, 3);
    while (!srst) @(posedge clk);
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (srst);
    chk("pulse", 16, k);
    chk("no irq", 0, irq);
    w(`OFF_CTRL, 0);
    w(`OFF_STATUS, 3);
    // Second reset in mid-run brings every register back to its reset value
    nrst <= 1'b0;
    m = '{0, 'hfff, 'hfff, 0, 0, 0, 0, 'hfff};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chk("srst after reset", 0, srst);
    chk("irq after reset", 0, irq);
    for (k = 0; k < 8; k++) if (k != 3) rv(8'(k * 4));
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: failure_watchdog_checker.sv
// Port-level assertions for the failure watchdog
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_defs.svh"

module failure_watchdog_checker
  import watchdog_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Register bus
  input wire axil_req_s axi_req_in,
  input wire axil_rsp_s axi_rsp_out,
  // Pins
  input wire logic low_speed_internal_oscillator_in,
  input wire logic low_speed_crystal_oscillator_in,
  input wire logic debug_halt_in,
  input wire logic irq_out,
  input wire logic sys_reset_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_rd_taken;
    axi_req_in.arvalid && axi_rsp_out.arready;
  endsequence
  sequence s_wr_taken;
    axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid && axi_rsp_out.wready && !axi_rsp_out.bvalid;
  endsequence
  // Pulse length fixed at 16 cycles
  sequence s_pulse16;
    sys_reset_out[*8] ##1 sys_reset_out[*8] ##1 !sys_reset_out;
  endsequence
  property p_rd_answer;
    s_rd_taken |=> axi_rsp_out.rvalid;
  endproperty
  property p_ar_blocked;
    axi_rsp_out.rvalid |-> !axi_rsp_out.arready;
  endproperty
  property p_r_hold;
    axi_rsp_out.rvalid && !axi_req_in.rready |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata);
  endproperty
  property p_r_done;
    axi_rsp_out.rvalid && axi_req_in.rready |=> !axi_rsp_out.rvalid;
  endproperty
  property p_b_hold;
    axi_rsp_out.bvalid && !axi_req_in.bready |=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp);
  endproperty
  property p_wr_answer;
    s_wr_taken |=> ##1 axi_rsp_out.bvalid;
  endproperty
  property p_one_response;
    !(irq_out && sys_reset_out);
  endproperty
  property p_reset_pulse;
    $rose(sys_reset_out) |-> s_pulse16;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_ar_blocked: assert property (p_ar_blocked) else $error("arready while rvalid");
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  a_r_done: assert property (p_r_done) else $error("rvalid after handshake");
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  a_one_response: assert property (p_one_response) else $error("both responses high");
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse length wrong");
endmodule

bind failure_watchdog failure_watchdog_checker i_failure_watchdog_checker (
  .core_clk_in(core_clk_in),
  .nrst_in(nrst_in),
  .axi_req_in(axi_req_in),
  .axi_rsp_out(axi_rsp_out),
  .low_speed_internal_oscillator_in(low_speed_internal_oscillator_in),
  .low_speed_crystal_oscillator_in(low_speed_crystal_oscillator_in),
  .debug_halt_in(debug_halt_in),
  .irq_out(irq_out),
  .sys_reset_out(sys_reset_out)
);
`default_nettype wire

// file: lowspeed_tick_sync.sv
// Synchronises the low-speed oscillators and debug halt, turns the chosen oscillator into a tick
`timescale 1ns/10ps
`default_nettype none

module lowspeed_tick_sync
  import watchdog_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Asynchronous pins
  input wire logic low_speed_internal_oscillator_in,
  input wire logic low_speed_crystal_oscillator_in,
  input wire logic debug_halt_in,
  // Control
  input wire logic clk_ext_in,
  // Results
  output logic tick_out,
  output logic halt_out
);

  typedef struct packed {
    logic [2:0] stg1;
    logic [2:0] stg2;
    logic [1:0] prev;
    logic tick;
  } sync_s;

  sync_s s_r;
  sync_s s_nxt;
  logic [1:0] rise;

  always_comb
  begin
    s_nxt = s_r;
    rise = s_r.stg2[1:0] & ~s_r.prev;
    s_nxt.stg1 = {debug_halt_in, low_speed_crystal_oscillator_in, low_speed_internal_oscillator_in};
    s_nxt.stg2 = s_r.stg1;
    // Both edge trackers run so a source switch gives no false tick
    s_nxt.prev = s_r.stg2[1:0];
    s_nxt.tick = clk_ext_in ? rise[1] : rise[0];
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick_out = s_r.tick;
  assign halt_out = s_r.stg2[2];

endmodule
`default_nettype wire

// file: tick_prescaler.sv
// Divides oscillator ticks by two to the power of the prescale setting
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_defs.svh"

module tick_prescaler
  import watchdog_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Control
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic [`PSC_W-1:0] div_in,
  // Result
  output logic dec_out
);

  typedef struct packed {
    logic [`PSC_CNT_W-1:0] cnt;
    logic dec;
  } psc_s;

  psc_s s_r;
  psc_s s_nxt;
  logic [`PSC_CNT_W-1:0] last;

  always_comb
  begin
    s_nxt = s_r;
    last = (`PSC_CNT_W'(1) << div_in) - `PSC_CNT_W'(1);
    s_nxt.dec = 1'b0;
    if (clear_in)
      s_nxt.cnt = '0;
    else if (tick_in)
    begin
      if (s_r.cnt >= last)
      begin
        s_nxt.cnt = '0;
        s_nxt.dec = 1'b1;
      end
      else
        s_nxt.cnt = s_r.cnt + `PSC_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign dec_out = s_r.dec;

endmodule
`default_nettype wire

// file: watchdog_defs.svh
// Constants for the failure watchdog: register map, field layout, keys, reset values
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

// --------------------------------------------------------------------------
// Widths
// --------------------------------------------------------------------------
`define ADDR_W 8
`define DATA_W 32
`define CNT_W 12
`define PSC_W 3
`define PSC_CNT_W 7
`define CTRL_W 7
`define EVT_W 2
`define HOLD_W 4

// --------------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_RELOAD 8'h04
`define OFF_DELTA 8'h08
`define OFF_KICK 8'h0c
`define OFF_LOCK 8'h10
`define OFF_STATUS 8'h14
`define OFF_MASK 8'h18
`define OFF_COUNT 8'h1c

// --------------------------------------------------------------------------
// Status and mask bit positions
// --------------------------------------------------------------------------
`define EVT_UNDERFLOW 0
`define EVT_EARLY 1

// --------------------------------------------------------------------------
// Keys and reset values
// --------------------------------------------------------------------------
`define KICK_KEY 32'h0000_5a3c
`define UNLOCK_KEY 32'h0000_c35a
`define CTRL_RST 7'h00
`define RELOAD_RST 12'hfff
`define DELTA_RST 12'hfff
`define MASK_RST 2'h0
`define RST_HOLD_CYC 4'hf

// --------------------------------------------------------------------------
// Bus responses
// --------------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: watchdog_pkg.sv
// Types shared by the failure watchdog modules
`default_nettype none
`include "watchdog_defs.svh"

package watchdog_pkg;

  typedef struct packed {
    logic [`ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [`DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [`ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [`DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_s;

  typedef struct packed {
    logic [`PSC_W-1:0] div;
    logic clk_ext;
    logic freeze;
    logic rst_mode;
    logic enable;
  } ctrl_s;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_RESP = 1'b1
  } wr_state_e;

endpackage
`default_nettype wire
